// file: src/card_status_defs.svh
// constants for the card status reporting block: offsets, bit positions, reset values
// assumes inclusion by bare name from the package and the design modules
`ifndef CARD_STATUS_DEFS_SVH
`define CARD_STATUS_DEFS_SVH

// register byte offsets on the bus
`define CSR_OFS_STATUS    8'h00
`define CSR_OFS_RESP      8'h04
`define CSR_OFS_IRQ_STAT  8'h08
`define CSR_OFS_IRQ_MASK  8'h0c
`define CSR_OFS_INFO      8'h10
`define CSR_ADDR_W        8

// status word field positions
`define CSR_BIT_OVW_ERR   16
`define CSR_BIT_ZERO14    14
`define CSR_BIT_ERASE_RST 13
`define CSR_BIT_STATE_LO  9
`define CSR_BIT_READY     8
`define CSR_FIELD_LO      8

// interrupt status bit positions
`define CSR_IRQ_OVW       0
`define CSR_IRQ_ERASE     1
`define CSR_IRQ_STATE     2
`define CSR_IRQ_W         3

// reset values
`define CSR_RST_MASK      3'h0
`define CSR_RST_WORD      32'h0000_0000

`endif

// file: src/card_status_pkg.sv
// types of the card status reporting block
// assumes card_status_defs.svh on the include path
`include "card_status_defs.svh"

package card_status_pkg;

  // card state numbers reported in the state field
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_READY = 4'h1,
    ST_IDENT = 4'h2,
    ST_STBY  = 4'h3,
    ST_TRAN  = 4'h4,
    ST_DATA  = 4'h5,
    ST_RCV   = 4'h6,
    ST_PRG   = 4'h7,
    ST_DIS   = 4'h8
  } card_state_t;

  // status word bits 16 down to 8
  typedef struct packed {
    logic       ovw_err;
    logic       wp15;
    logic       zero14;
    logic       erase_reset;
    logic [3:0] state;
    logic       ready;
  } status_field_t;

  // one accepted bus access
  typedef struct packed {
    logic                   valid;
    logic                   write;
    logic [`CSR_ADDR_W-1:0] addr;
  } bus_access_t;

  // write-side events raised by the card logic
  typedef struct packed {
    logic cid_write;
    logic csd_write;
    logic csd_ro_mismatch;
    logic copy_clear_try;
    logic perm_wp_clear_try;
  } write_event_t;

endpackage : card_status_pkg

// file: src/sticky_flags.sv
// bank of sticky flags where a set in the same cycle beats a clear
// assumes synchronous active-high reset
`timescale 1ns/1ps

module sticky_flags #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // set and clear per flag
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // flags
  output logic      [W-1:0] q
);

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= set | (q & ~clr);
    end
  end

endmodule : sticky_flags

// file: src/ahb_slave_port.sv
// AHB-Lite slave front end: address phase decode and data phase write strobe
// assumes one slave on the bus, zero wait states, single word transfers
`timescale 1ns/1ps
`include "card_status_defs.svh"

module ahb_slave_port (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // bus address phase
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic                         hready,
  // read taken this cycle (address phase)
  output card_status_pkg::bus_access_t      rd_acc,
  // write due this cycle (data phase)
  output card_status_pkg::bus_access_t      wr_acc
);

  logic take;

  // NONSEQ or SEQ with the bus ready; only word accesses act
  assign take = hsel & htrans[1] & hready & (hsize == 3'h2);

  assign rd_acc.valid = take & ~hwrite;
  assign rd_acc.write = 1'b0;
  assign rd_acc.addr  = haddr[`CSR_ADDR_W-1:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_acc <= '0;
    end else begin
      wr_acc.valid <= take & hwrite;
      wr_acc.write <= 1'b1;
      wr_acc.addr  <= haddr[`CSR_ADDR_W-1:0];
    end
  end

endmodule : ahb_slave_port

// file: src/card_status_reporting.sv
// card status word bits 16 to 8 with an AHB-Lite register view and an interrupt
// assumes card logic events are one-cycle pulses synchronous to clk
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "card_status_defs.svh"

module card_status_reporting (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // AHB-Lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // command side of the card
  input  wire logic                          cmd_stb,
  input  wire logic                          cmd_in_erase_seq,
  input  wire logic                          erase_pending,
  input  wire card_status_pkg::card_state_t  card_state,
  input  wire logic                          buf_empty,
  input  wire logic                          resp_done,
  // register write events of the card
  input  wire card_status_pkg::write_event_t wr_evt,
  // response status word and interrupt
  output logic      [31:0]                   resp_word,
  output logic                               resp_valid,
  output logic                               irq
);

  card_status_pkg::bus_access_t  rd_acc;
  card_status_pkg::bus_access_t  wr_acc;
  card_status_pkg::status_field_t live_f;
  card_status_pkg::status_field_t resp_f_q;
  card_status_pkg::card_state_t  prev_state_q;

  logic                 cid_programmed_q;
  logic                 ovw_set;
  logic                 erase_abort;
  logic                 state_change;
  logic [1:0]           err_set;
  logic [1:0]           err_clr;
  logic [1:0]           err_q;
  logic [1:0]           err_fresh_q;
  logic [`CSR_IRQ_W-1:0] irq_set;
  logic [`CSR_IRQ_W-1:0] irq_clr;
  logic [`CSR_IRQ_W-1:0] irq_stat_q;
  logic [`CSR_IRQ_W-1:0] irq_mask_q;
  logic [31:0]          rd_word;
  logic                 rd_stat;

  // status field into its place in the 32-bit word
  function automatic logic [31:0] place_field(
    input card_status_pkg::status_field_t f
  );
    logic [31:0] w;
    w = `CSR_RST_WORD;
    w[`CSR_BIT_OVW_ERR:`CSR_FIELD_LO] = f;
    return w;
  endfunction : place_field

  // bus front end
  ahb_slave_port u_port (
    .clk    (clk),
    .rst    (rst),
    .hsel   (hsel),
    .haddr  (haddr),
    .htrans (htrans),
    .hwrite (hwrite),
    .hsize  (hsize),
    .hready (hready),
    .rd_acc (rd_acc),
    .wr_acc (wr_acc)
  );

  // identification register programmed once since reset
  always_ff @(posedge clk) begin
    if (rst) begin
      cid_programmed_q <= 1'b0;
    end else if (wr_evt.cid_write) begin
      cid_programmed_q <= 1'b1;
    end
  end

  // overwrite error sources
  always_comb begin
    ovw_set = 1'b0;
    if (wr_evt.cid_write && cid_programmed_q) begin
      ovw_set = 1'b1;
    end
    if (wr_evt.csd_write && wr_evt.csd_ro_mismatch) begin
      ovw_set = 1'b1;
    end
    if (wr_evt.copy_clear_try || wr_evt.perm_wp_clear_try) begin
      ovw_set = 1'b1;
    end
  end

  // a command outside the erase sequence drops a pending erase
  assign erase_abort = cmd_stb & erase_pending & ~cmd_in_erase_seq;

  // error bits held until returned; a new set in the same cycle wins
  assign err_set = {ovw_set, erase_abort};
  // raised again after the snapshot: not returned yet, so it must survive the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      err_fresh_q <= 2'h0;
    end else if (cmd_stb) begin
      err_fresh_q <= 2'h0;
    end else begin
      err_fresh_q <= err_fresh_q | err_set;
    end
  end

  assign err_clr = resp_done ? ({resp_f_q.ovw_err, resp_f_q.erase_reset} & ~err_fresh_q)
                             : 2'h0;

  sticky_flags #(
    .W (2)
  ) u_err (
    .clk (clk),
    .rst (rst),
    .set (err_set),
    .clr (err_clr),
    .q   (err_q)
  );

  // live view of the status field
  always_comb begin
    live_f             = '0;
    live_f.ovw_err     = err_q[1];
    live_f.wp15        = 1'b0;
    live_f.zero14      = 1'b0;
    live_f.erase_reset = err_q[0];
    live_f.state       = card_state;
    live_f.ready       = buf_empty;
  end

  // snapshot at command arrival: state before the command acts
  always_ff @(posedge clk) begin
    if (rst) begin
      resp_f_q <= '0;
    end else if (cmd_stb) begin
      resp_f_q             <= live_f;
      resp_f_q.ovw_err     <= err_q[1] | ovw_set;
      resp_f_q.erase_reset <= err_q[0] | erase_abort;
      resp_f_q.state       <= card_state;
      resp_f_q.ready       <= buf_empty;
      resp_f_q.zero14      <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resp_word <= `CSR_RST_WORD;
    end else if (cmd_stb) begin
      resp_word <= place_field(live_f);
      resp_word[`CSR_BIT_OVW_ERR] <= err_q[1] | ovw_set;
      resp_word[`CSR_BIT_ERASE_RST] <= err_q[0] | erase_abort;
      resp_word[`CSR_BIT_ZERO14] <= 1'b0;
    end
  end

  // response pending until the card reports it returned
  always_ff @(posedge clk) begin
    if (rst) begin
      resp_valid <= 1'b0;
    end else if (cmd_stb) begin
      resp_valid <= 1'b1;
    end else if (resp_done) begin
      resp_valid <= 1'b0;
    end
  end

  // state change detection for the interrupt
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_state_q <= card_status_pkg::ST_IDLE;
    end else begin
      prev_state_q <= card_state;
    end
  end

  assign state_change = (card_state != prev_state_q);

  // interrupt status, cleared by a read of its register
  assign rd_stat = rd_acc.valid && (rd_acc.addr == `CSR_OFS_IRQ_STAT);

  always_comb begin
    irq_set                 = '0;
    irq_set[`CSR_IRQ_OVW]   = ovw_set;
    irq_set[`CSR_IRQ_ERASE] = erase_abort;
    irq_set[`CSR_IRQ_STATE] = state_change;
  end

  assign irq_clr = rd_stat ? irq_stat_q : '0;

  sticky_flags #(
    .W (`CSR_IRQ_W)
  ) u_irq (
    .clk (clk),
    .rst (rst),
    .set (irq_set),
    .clr (irq_clr),
    .q   (irq_stat_q)
  );

  // mask register, written in the data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_q <= `CSR_RST_MASK;
    end else if (wr_acc.valid && (wr_acc.addr == `CSR_OFS_IRQ_MASK)) begin
      irq_mask_q <= hwdata[`CSR_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // read decode; unmapped offsets read zero
  always_comb begin
    rd_word = `CSR_RST_WORD;
    if (rd_acc.addr == `CSR_OFS_STATUS) begin
      rd_word = place_field(live_f);
    end else if (rd_acc.addr == `CSR_OFS_RESP) begin
      rd_word = resp_word;
    end else if (rd_acc.addr == `CSR_OFS_IRQ_STAT) begin
      rd_word[`CSR_IRQ_W-1:0] = irq_stat_q;
    end else if (rd_acc.addr == `CSR_OFS_IRQ_MASK) begin
      rd_word[`CSR_IRQ_W-1:0] = irq_mask_q;
    end else if (rd_acc.addr == `CSR_OFS_INFO) begin
      rd_word[1:0] = {resp_valid, cid_programmed_q};
    end
  end

  // read data captured at the address phase edge, shown in the data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= `CSR_RST_WORD;
    end else if (rd_acc.valid) begin
      hrdata <= rd_word;
    end
  end

  // zero wait states, always OKAY
  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule : card_status_reporting

// file: testbench/card_status_asserts.sv
// checker: response snapshot and error bits of the status block
// assumes bind to card_status_reporting, rst synchronous active high
`timescale 1ns/1ps

module card_status_asserts (
  // clock and reset
  input wire logic                          clk,
  input wire logic                          rst,
  // card side
  input wire logic                          cmd_stb,
  input wire logic                          cmd_in_erase_seq,
  input wire logic                          erase_pending,
  input wire card_status_pkg::card_state_t  card_state,
  input wire logic                          buf_empty,
  input wire logic                          resp_done,
  input wire card_status_pkg::write_event_t wr_evt,
  input wire logic [31:0]                   resp_word,
  input wire logic                          resp_valid,
  input wire logic                          irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic cid_q, evt_q, clean_q;

  // id written once; event since snapshot; flags returned with nothing new
  always_ff @(posedge clk) begin
    if (rst) cid_q <= 1'b0;
    else if (wr_evt.cid_write) cid_q <= 1'b1;
  end
  always_ff @(posedge clk) begin
    if (rst || cmd_stb) evt_q <= 1'b0;
    else if (wr_evt != '0) evt_q <= 1'b1;
  end
  always_ff @(posedge clk) begin
    if (rst) clean_q <= 1'b0;
    else if (resp_done && resp_valid && !cmd_stb && !evt_q && wr_evt == '0) clean_q <= 1'b1;
    else if (cmd_stb || wr_evt != '0) clean_q <= 1'b0;
  end

  a_cid_again: assert property (wr_evt.cid_write && cid_q ##1 cmd_stb
    |=> resp_word[16]) else $error("id rewrite not flagged");
  a_csd_ro: assert property (wr_evt.csd_write && wr_evt.csd_ro_mismatch ##1 cmd_stb
    |=> resp_word[16]) else $error("csd mismatch not flagged");
  a_flag_back: assert property ((wr_evt.copy_clear_try || wr_evt.perm_wp_clear_try)
    ##1 cmd_stb |=> resp_word[16]) else $error("flag clear not flagged");
  a_zero_bit: assert property (!resp_word[14]) else $error("bit 14 set");
  a_erase_drop: assert property (cmd_stb && erase_pending && !cmd_in_erase_seq
    |=> resp_word[13]) else $error("erase abort not flagged");
  a_state_snap: assert property (cmd_stb |=> resp_word[12:9] == $past(card_state))
    else $error("state field wrong");
  a_word_stands: assert property (!cmd_stb |=> $stable(resp_word))
    else $error("response changed without command");
  a_ready_bit: assert property (cmd_stb |=> resp_word[8] == $past(buf_empty))
    else $error("ready bit wrong");
  a_err_return: assert property (clean_q && cmd_stb && wr_evt == '0 && !erase_pending
    |=> resp_word[16:13] == 4'h0) else $error("error bit not cleared");

  c_ovw: cover property (cmd_stb ##1 resp_word[16]);
  c_done: cover property (resp_done ##1 !resp_valid);
  c_irq: cover property ($rose(irq));
endmodule : card_status_asserts

bind card_status_reporting card_status_asserts u_chk (
  .clk, .rst, .cmd_stb, .cmd_in_erase_seq, .erase_pending, .card_state, .buf_empty,
  .resp_done, .wr_evt, .resp_word, .resp_valid, .irq
);

// file: testbench/host_cmd_model.sv
// host side of the card command bus: issues commands, returns responses
// assumes the card raises resp_valid after cmd_stb and drops it on resp_done
`timescale 1ns/1ps

module host_cmd_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // requests from the bench
  input  wire logic       go,
  input  wire logic       ins,
  input  wire logic [3:0] lat,
  // card side
  input  wire logic       resp_valid,
  output logic            cmd_stb,
  output logic            cmd_in_erase_seq,
  output logic            resp_done
);
  logic [3:0] cnt_q;

  // erase qualifier means nothing between commands, so it toggles there
  always_ff @(posedge clk) begin
    cmd_stb <= go && !rst;
    cmd_in_erase_seq <= go ? ins : (rst ? 1'b0 : !cmd_in_erase_seq);
  end

  // response returned lat+1 cycles after it appears
  always_ff @(posedge clk) begin
    if (rst || !resp_valid || resp_done) cnt_q <= 4'h0;
    else cnt_q <= cnt_q + 4'h1;
    resp_done <= !rst && resp_valid && !resp_done && cnt_q == lat;
  end
endmodule : host_cmd_model

// file: testbench/card_status_reporting_tb.sv
// bench for the status block: register reads, command snapshots, errors, irq
// assumes host_cmd_model on the command side and the bound checker
`timescale 1ns/1ps

module card_status_reporting_tb;
  logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, ins = 1'b0;
  logic        erase_pending = 1'b0, buf_empty = 1'b1, ab = 1'b0;
  logic        hreadyout, hresp, cmd_stb, cmd_in_erase_seq, resp_done, resp_valid, irq;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  lat = 4'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, resp_word, rd, x, e;
  logic [4:0]  evts [6] = '{5'h10, 5'h10, 5'h08, 5'h0c, 5'h02, 5'h01};
  logic        ovw [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [7:0]  offs [5] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14};
  int          n_fail = 0, n_tests = 0;
  card_status_pkg::card_state_t  card_state = card_status_pkg::ST_IDLE;
  card_status_pkg::write_event_t wr_evt = '0;

  always #4 clk = ~clk;

  card_status_reporting DUT (
    .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .cmd_stb, .cmd_in_erase_seq, .erase_pending,
    .card_state, .buf_empty, .resp_done, .wr_evt, .resp_word, .resp_valid, .irq
  );
  host_cmd_model host (
    .clk, .rst, .go, .ins, .lat, .resp_valid, .cmd_stb, .cmd_in_erase_seq, .resp_done
  );

  function automatic logic [31:0] word(logic ov, logic er, logic [3:0] s, logic r);
    return {15'h0, ov, 2'b00, er, s, r, 8'h00};
  endfunction : word

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  // bounded wait for bus ready or a response level
  task automatic wait_on(logic on_rv, logic lvl);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if ((on_rv ? resp_valid : hreadyout) === lvl) break;
    end
    if (i == 40) begin
      n_fail++;
      summarize();
    end
  endtask : wait_on

  task automatic bus(logic w, logic [7:0] a, logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_on(1'b0, 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_on(1'b0, 1'b1);
    rd = hrdata;
    chk("hresp okay", {31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic cmd(logic [4:0] ev, logic [31:0] exp, string name);
    go <= 1'b1;
    wr_evt <= ev;
    @(posedge clk);
    go <= 1'b0;
    wr_evt <= '0;
    @(posedge clk);
    card_state <= card_status_pkg::card_state_t'($urandom_range(8));
    wait_on(1'b1, 1'b1);
    chk(name, resp_word, exp);
    wait_on(1'b1, 1'b0);
  endtask : cmd

  initial begin
    x = $urandom(41);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b1, 8'h00, 32'hffff_ffff);
    foreach (offs[i]) begin
      bus(1'b0, offs[i], 32'h0);
      chk("reset read", rd, i == 0 ? 32'h100 : 32'h0);
    end
    $display("reset test done");
    for (int k = 0; k < 18; k++) begin
      x = $urandom;
      e = word(1'b0, x[1] & !x[2], 4'(k % 9), x[0]);
      ab = ab | (x[1] & !x[2]);
      card_state <= card_status_pkg::card_state_t'(k % 9);
      buf_empty <= x[0];
      erase_pending <= x[1];
      ins <= x[2];
      lat <= {2'b00, x[5:4]};
      cmd(5'h0, e, "snapshot");
      bus(1'b0, 8'h04, 32'h0);
      chk("response stands", rd, e);
    end
    $display("snapshot test done");
    erase_pending <= 1'b0;
    bus(1'b1, 8'h0c, 32'h1);
    bus(1'b0, 8'h08, 32'h0);
    chk("irq events", rd, {29'h0, 1'b1, ab, 1'b0});
    for (int k = 0; k < 6; k++) begin
      cmd(evts[k], word(ovw[k], 1'b0, card_state, buf_empty), "overwrite");
      chk("irq raised", {31'h0, irq}, {31'h0, ovw[k]});
      bus(1'b0, 8'h08, 32'h0);
      chk("irq status", {31'h0, rd[0]}, {31'h0, ovw[k]});
      repeat (2) @(posedge clk);
      chk("irq cleared", {31'h0, irq}, 32'h0);
    end
    cmd(5'h0, word(1'b0, 1'b0, card_state, buf_empty), "error returned");
    bus(1'b1, 8'h0c, 32'h0);
    cmd(5'h10, word(1'b1, 1'b0, card_state, buf_empty), "masked error");
    chk("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b1, 8'h0c, 32'hffff_ffff);
    bus(1'b0, 8'h0c, 32'h0);
    chk("mask bits", rd, 32'h7);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    hsize <= 3'h1;
    bus(1'b1, 8'h0c, 32'h0);
    hsize <= 3'h2;
    bus(1'b0, 8'h0c, 32'h0);
    chk("narrow write ignored", rd, 32'h7);
    $display("error test done");
    summarize();
  end
endmodule : card_status_reporting_tb
